// file: dv/cpu_clock_ready_reset_gen_bench.sv
// self-checking bench for the clock, ready and reset core
`timescale 1ns/1ns
`default_nettype none
module cpu_clock_ready_reset_gen_bench;
  // ==========================================
  // bench state
  int   err_total = 0;    // mismatches
  int   n_tests   = 0;    // comparisons
  int   cyc       = 0;    // core cycle count
  logic core_clk  = 1'b0; // core clock
  logic arst_n    = 1'b0; // block asynchronous reset
  logic clear_req = 1'b0; // clear request to model
  logic strap     = 1'b0; // source select
  logic trigger   = 1'b0; // reset trigger
  logic ready_one = 1'b0; // ready one
  logic q1n       = 1'b1; // qualifier one
  logic ready_two = 1'b0; // ready two
  logic q2n       = 1'b1; // qualifier two
  logic stage     = 1'b1; // stage select
  logic xtal, ext_freq, clr; // model pins
  logic proc_clk, periph_clk, tap, bus_ready, proc_reset;
  // clock and cycle counter
  always #(crg_pkg::CORE_PERIOD_NS / 2) core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  // ==========================================
  // block and partner
  crg_core DUT (
    .CORE_CLK              (core_clk),
    .ARST_N                (arst_n),
    .CRYSTAL_PINS          (xtal),
    .EXTERNAL_FREQUENCY_IN (ext_freq),
    .FREQ_SOURCE_STRAP     (strap),
    .PHASE_ALIGN_CLEAR     (clr),
    .BUS_READY_IN_ONE      (ready_one),
    .BUS_READY_IN_TWO      (ready_two),
    .BUS_QUALIFIER_ONE_N   (q1n),
    .BUS_QUALIFIER_TWO_N   (q2n),
    .SYNC_STAGE_SELECT     (stage),
    .POWER_ON_TRIGGER_IN   (trigger),
    .PROC_CLK              (proc_clk),
    .PERIPH_CLK            (periph_clk),
    .CRYSTAL_TAP_OUT       (tap),
    .BUS_READY             (bus_ready),
    .PROC_RESET            (proc_reset)
  );
  crg_src_model SRC (
    .clear_req             (clear_req),
    .crystal_pins          (xtal),
    .external_frequency_in (ext_freq),
    .phase_align_clear     (clr)
  );
  // ==========================================
  // shared helpers
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    err_total++;
    $display("unexpected at %0t: %s", $time, m);
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_tests++;
    if (got !== exp) fail(m);
  endtask
  // step n edges, settle after each
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = proc_clk;
      1: pick = periph_clk;
      default: pick = tap;
    endcase
  endfunction
  // bounded wait for a level
  task automatic wait_lvl(input int sel, input logic v);
    int i;
    i = 0;
    while (pick(sel) !== v && i < 2000) begin
      tick(1);
      i++;
    end
    if (i == 2000) begin
      fail("wait bound used up");
      final_report();
    end
  endtask
  // n processor clock falls
  task automatic fall(input int n);
    repeat (n) begin
      wait_lvl(0, 1'b1);
      wait_lvl(0, 1'b0);
    end
  endtask
  // high time and period in core cycles
  task automatic meas(input int sel, input int hi, input int per);
    int t0;
    wait_lvl(sel, 1'b0);
    wait_lvl(sel, 1'b1);
    t0 = cyc;
    wait_lvl(sel, 1'b0);
    cmp(8'(cyc - t0), 8'(hi), "high time");
    wait_lvl(sel, 1'b1);
    cmp(8'(cyc - t0), 8'(per), "period");
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    tick(3);
    cmp(8'({proc_clk, periph_clk, tap, bus_ready, proc_reset}), 8'h01, "reset values");
    arst_n = 1'b1;
    $display("test reset done");
  endtask
  task automatic t_clocks(input logic s, input int src);
    strap = s;
    tick(300);
    meas(0, src, 3 * src); // source and divide by three
    meas(1, 3 * src, 6 * src); // peripheral clock
    meas(2, 7, 14); // crystal tap
    $display("test clocks done");
  endtask
  task automatic t_clear();
    int hits;
    hits = 0;
    clear_req = 1'b1;
    tick(100);
    repeat (150) begin
      tick(1);
      if (proc_clk !== 1'b0 || periph_clk !== 1'b0) hits++;
    end
    cmp(8'(hits), 8'h00, "clocks ran in clear"); // counting held
    clear_req = 1'b0;
    wait_lvl(0, 1'b1); // counting resumes
    $display("test clear done");
  endtask
  task automatic t_rst();
    logic prev;
    int   i;
    fall(1);
    cmp(8'(proc_reset), 8'h01, "reset left early");
    trigger = 1'b1;
    prev = proc_clk;
    i = 0;
    while (proc_reset === 1'b1 && i < 500) begin
      prev = proc_clk;
      tick(1);
      i++;
    end
    cmp(8'({prev, proc_clk, proc_reset}), 8'h04, "reset edge");
    $display("test reset out done");
  endtask
  task automatic t_qual();
    logic [4:0] tbl [0:5] = '{5'h1A, 5'h13, 5'h0E, 5'h0D, 5'h00, 5'h15};
    stage = 1'b1;
    for (int k = 0; k < 6; k++) begin
      {ready_one, q1n, ready_two, q2n} = tbl[k][4:1]; // qualifier pairs
      fall(2);
      cmp(8'(bus_ready), 8'(tbl[k][0]), "qualified ready");
    end
    $display("test qualifiers done");
  endtask
  task automatic t_stage(input logic st);
    {ready_one, q1n, ready_two, q2n} = 4'h1;
    stage = st; // mode per bus cycle
    fall(2);
    wait_lvl(0, 1'b1);
    ready_one = 1'b1;
    fall(1);
    cmp(8'(bus_ready), 8'(st), "first fall");
    fall(1);
    cmp(8'(bus_ready), 8'h01, "second fall");
    wait_lvl(0, 1'b1);
    ready_one = 1'b0;
    tick(8);
    cmp(8'(bus_ready), 8'h01, "early drop");
    fall(1);
    cmp(8'(bus_ready), 8'h00, "drop at fall");
    $display("test stage done");
  endtask
  // ==========================================
  // main sequence
  initial begin
    t_reset();
    t_clocks(1'b0, 14);
    t_clocks(1'b1, 22);
    t_clear();
    t_rst();
    t_qual();
    t_stage(1'b0);
    t_stage(1'b1);
    final_report();
  end
endmodule
`default_nettype wire

// file: dv/crg_src_model.sv
// partner model: frequency sources and clear synchroniser
`timescale 1ns/1ns
`default_nettype none
module crg_src_model (
  // request from the bench
  input  wire logic clear_req,
  // source pins toward the block
  output logic      crystal_pins,
  output logic      external_frequency_in,
  output logic      phase_align_clear
);
  logic clr_meta;  // first clear flop
  // ==========================================
  // crystal, 140 ns period, free running
  initial begin
    crystal_pins = 1'b0;
    #3;
    forever #70 crystal_pins = ~crystal_pins;
  end
  // external source, 220 ns period, own phase
  initial begin
    external_frequency_in = 1'b0;
    #7;
    forever #110 external_frequency_in = ~external_frequency_in;
  end
  // ==========================================
  // clear starts low
  initial begin
    clr_meta = 1'b0;
    phase_align_clear = 1'b0;
  end
  // bench keeps clear low on crystal
  always @(posedge external_frequency_in) begin
    clr_meta <= clear_req;
    phase_align_clear <= clr_meta;
  end
endmodule
`default_nettype wire

// file: inc/crg_pkg.sv
// constants for the processor clock, ready and reset generator
// Summary of operation
// - each ready honoured only with its qualifier low
// - stage select high one stage, low two
// - ready drops only at processor clock falling edge
// - strap high picks external input, low crystal
// - processor clock is source/3, one-third high
// - phase clear high holds counters at zero
// - peripheral clock half processor clock, 50% duty
// - crystal tap always carries crystal frequency
// - reset output changes on processor clock falling edge
// - two-stage rise: first flop rising, second falling
// - two-stage fall: straight to second flop falling
// - one-stage: only second flop on falling edge
package crg_pkg;
  // ==========================================
  // core clock
  localparam int unsigned CORE_PERIOD_NS = 10;
  // ==========================================
  // divider
  localparam logic [1:0]  DIV_FIRST      = 2'h0;
  localparam logic [1:0]  DIV_LAST       = 2'h2;
  // ==========================================
  // positions in the synchronised pin vector
  localparam int unsigned PIN_XTAL       = 0;
  localparam int unsigned PIN_EXT_FREQ   = 1;
  localparam int unsigned PIN_STRAP      = 2;
  localparam int unsigned PIN_CLEAR      = 3;
  localparam int unsigned PIN_READY_ONE  = 4;
  localparam int unsigned PIN_READY_TWO  = 5;
  localparam int unsigned PIN_QUAL1_N    = 6;
  localparam int unsigned PIN_QUAL2_N    = 7;
  localparam int unsigned PIN_STAGE      = 8;
  localparam int unsigned PIN_TRIG       = 9;
  localparam int unsigned PIN_WIDTH      = 10;
  // ==========================================
  // reset values
  localparam logic [9:0]  PIN_RST_VAL    = 10'h100;
  localparam logic        RESET_OUT_RST  = 1'b1;
endpackage

// file: inc/crg_sync_if.sv
// carrier between pin synchroniser and generator core
`timescale 1ns/1ns
`default_nettype none
interface crg_sync_if #(parameter int unsigned W = 10);
  logic [W-1:0] raw;    // pin levels as they arrive
  logic [W-1:0] clean;  // levels after second- and third-flop agreement
  // synchroniser side
  modport sync (input raw, output clean);
  // user side
  modport user (output raw, input clean);
endinterface
`default_nettype wire

// file: rtl/crg_core.sv
// processor clock, ready and reset generator core
`timescale 1ns/1ns
`default_nettype none
module crg_core (
  // core clock and reset
  input  wire logic CORE_CLK,
  input  wire logic ARST_N,
  // frequency sources
  input  wire logic CRYSTAL_PINS,
  input  wire logic EXTERNAL_FREQUENCY_IN,
  input  wire logic FREQ_SOURCE_STRAP,
  input  wire logic PHASE_ALIGN_CLEAR,
  // bus ready inputs
  input  wire logic BUS_READY_IN_ONE,
  input  wire logic BUS_READY_IN_TWO,
  input  wire logic BUS_QUALIFIER_ONE_N,
  input  wire logic BUS_QUALIFIER_TWO_N,
  input  wire logic SYNC_STAGE_SELECT,
  // reset trigger
  input  wire logic POWER_ON_TRIGGER_IN,
  // generated clocks
  output logic      PROC_CLK,
  output logic      PERIPH_CLK,
  output logic      CRYSTAL_TAP_OUT,
  // processor handshakes
  output logic      BUS_READY,
  output logic      PROC_RESET
);
  // ==========================================
  // pin synchronisation
  crg_sync_if #(.W(crg_pkg::PIN_WIDTH)) pin_bus ();

  assign pin_bus.raw = {POWER_ON_TRIGGER_IN, SYNC_STAGE_SELECT, BUS_QUALIFIER_TWO_N,
                        BUS_QUALIFIER_ONE_N, BUS_READY_IN_TWO, BUS_READY_IN_ONE,
                        PHASE_ALIGN_CLEAR, FREQ_SOURCE_STRAP, EXTERNAL_FREQUENCY_IN,
                        CRYSTAL_PINS};

  crg_pin_sync #(
    .W       (crg_pkg::PIN_WIDTH),
    .RST_VAL (crg_pkg::PIN_RST_VAL)
  ) u_pin_sync (
    .clk    (CORE_CLK),
    .arst_n (ARST_N),
    .pins   (pin_bus.sync)
  );

  // clean pin levels
  logic xtal_lvl;   // crystal oscillator level
  logic ext_freq_lvl; // external frequency level
  logic strap_lvl;  // source strap
  logic clear_lvl;  // phase align clear
  logic ready_one_lvl; // ready one
  logic ready_two_lvl; // ready two
  logic qual1_n;    // qualifier one, low active
  logic qual2_n;    // qualifier two, low active
  logic stage_lvl;  // stage select, high = one stage
  logic trig_lvl;   // reset trigger

  assign xtal_lvl  = pin_bus.clean[crg_pkg::PIN_XTAL];
  assign ext_freq_lvl  = pin_bus.clean[crg_pkg::PIN_EXT_FREQ];
  assign strap_lvl = pin_bus.clean[crg_pkg::PIN_STRAP];
  assign clear_lvl = pin_bus.clean[crg_pkg::PIN_CLEAR];
  assign ready_one_lvl = pin_bus.clean[crg_pkg::PIN_READY_ONE];
  assign ready_two_lvl = pin_bus.clean[crg_pkg::PIN_READY_TWO];
  assign qual1_n   = pin_bus.clean[crg_pkg::PIN_QUAL1_N];
  assign qual2_n   = pin_bus.clean[crg_pkg::PIN_QUAL2_N];
  assign stage_lvl = pin_bus.clean[crg_pkg::PIN_STAGE];
  assign trig_lvl  = pin_bus.clean[crg_pkg::PIN_TRIG];

  // ==========================================
  // state
  typedef struct packed {
    logic [1:0] cnt;       // divide-by-three phase
    logic       src_prev;  // previous selected source level
    logic       proc_clk;  // processor clock
    logic       periph_clk;// peripheral clock
    logic       tap;       // crystal tap copy
    logic       rdy_ff1;   // ready first flop
    logic       rdy_ff2;   // ready second flop, drives ready
    logic       reset_out; // processor reset
  } crg_core_s;

  crg_core_s st_reg;  // registered state
  crg_core_s st_next; // next state

  logic src_lvl;     // selected source level
  logic src_rise;    // selected source rising
  logic clk_rise;    // processor clock rising this edge
  logic clk_fall;    // processor clock falling this edge
  logic rdy_qual;    // qualified combined ready

  // ==========================================
  // next-state logic
  always_comb begin
    st_next = st_reg;
    // strap chooses counter source
    // source select strap
    src_lvl  = strap_lvl ? ext_freq_lvl : xtal_lvl;
    src_rise = src_lvl & ~st_reg.src_prev;
    st_next.src_prev = src_lvl;
    // divider advances on source rising edge
    if (src_rise) begin
      if (clear_lvl) begin
        st_next.cnt = crg_pkg::DIV_FIRST;
      end else if (st_reg.cnt == crg_pkg::DIV_LAST) begin
        st_next.cnt = crg_pkg::DIV_FIRST;
      end else begin
        st_next.cnt = st_reg.cnt + 2'h1;
      end
    end
    // high for one source period of three
    st_next.proc_clk = (st_next.cnt == crg_pkg::DIV_LAST);
    clk_rise = st_next.proc_clk & ~st_reg.proc_clk;
    clk_fall = ~st_next.proc_clk & st_reg.proc_clk;
    if (src_rise && clear_lvl) begin
      st_next.periph_clk = 1'b0;
    end else if (clk_rise) begin
      st_next.periph_clk = ~st_reg.periph_clk;
    end
    st_next.tap = xtal_lvl;
    rdy_qual = (ready_one_lvl & ~qual1_n) | (ready_two_lvl & ~qual2_n);
    if (clk_rise) begin
      st_next.rdy_ff1 = rdy_qual;
    end
    // second flop only on falling edge
    if (clk_fall) begin
      if (stage_lvl) begin
        st_next.rdy_ff2 = rdy_qual;
      end else if (!rdy_qual) begin
        st_next.rdy_ff2 = 1'b0;
      end else begin
        st_next.rdy_ff2 = st_reg.rdy_ff1;
      end
      st_next.reset_out = ~trig_lvl;
    end
  end

  // state register
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_reg           <= '0;
      st_reg.reset_out <= crg_pkg::RESET_OUT_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs from flops
  assign PROC_CLK        = st_reg.proc_clk;
  assign PERIPH_CLK      = st_reg.periph_clk;
  assign CRYSTAL_TAP_OUT = st_reg.tap;
  // ready drops only at falling edge
  assign BUS_READY       = st_reg.rdy_ff2;
  assign PROC_RESET      = st_reg.reset_out;

  // ==========================================
  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  chk_one_stage_ready: assert property (
    (clk_fall && stage_lvl) |=> (BUS_READY == $past(rdy_qual)))
    else $error("one-stage ready not taken at falling edge");
  chk_two_stage_fall: assert property (
    (clk_fall && !stage_lvl && !rdy_qual) |=> !BUS_READY)
    else $error("two-stage ready did not drop");
  chk_two_stage_rise: assert property (
    (clk_fall && !stage_lvl && !st_reg.rdy_ff1) |=> !BUS_READY)
    else $error("two-stage ready rose without first flop");
  chk_qualifier_gate: assert property (
    (clk_fall && stage_lvl && qual1_n && qual2_n) |=> !BUS_READY)
    else $error("ready accepted without qualifier");
  chk_ready_drop_edge: assert property (
    $fell(BUS_READY) |-> $past(clk_fall))
    else $error("ready dropped away from falling edge");
  chk_clock_high_one: assert property (
    (src_rise && PROC_CLK) |=> !PROC_CLK)
    else $error("processor clock high over one source period");
  chk_clear_holds: assert property (
    (src_rise && clear_lvl) |=> (st_reg.cnt == crg_pkg::DIV_FIRST && !PROC_CLK && !PERIPH_CLK))
    else $error("clear did not hold counters");
  chk_periph_edge: assert property (
    $changed(PERIPH_CLK) |-> ($past(clk_rise) || ($past(src_rise) && $past(clear_lvl))))
    else $error("peripheral clock changed off clock edge");
  chk_reset_edge: assert property (
    $changed(PROC_RESET) |-> $past(clk_fall))
    else $error("reset changed off falling edge");
  chk_reset_level: assert property (
    (clk_fall && trig_lvl) |=> !PROC_RESET ##1 (!PROC_RESET || $past(clk_fall)))
    else $error("reset not released after trigger high");
  chk_tap_follows: assert property (
    ##1 (CRYSTAL_TAP_OUT == $past(xtal_lvl)))
    else $error("crystal tap does not follow crystal");

  // ==========================================
  // divider and ready flop checks
  chk_source_select: assert property (
    (strap_lvl && $past(strap_lvl) && $rose(ext_freq_lvl)) |-> src_rise)
    else $error("external source edge not used with strap high");
  chk_crystal_select: assert property (
    (!strap_lvl && !$past(strap_lvl) && $rose(xtal_lvl)) |-> src_rise)
    else $error("crystal edge not used with strap low");
  chk_count_range: assert property (
    st_reg.cnt <= crg_pkg::DIV_LAST)
    else $error("divider count out of range");
  chk_count_still: assert property (
    !src_rise |=> $stable(st_reg.cnt))
    else $error("divider moved without source edge");
  chk_first_flop: assert property (
    clk_rise |=> (st_reg.rdy_ff1 == $past(rdy_qual)))
    else $error("first ready flop missed clock rise");
  chk_ready_hold: assert property (
    !clk_fall |=> $stable(BUS_READY))
    else $error("ready changed away from falling edge");
  chk_periph_toggle: assert property (
    clk_rise |=> (PERIPH_CLK != $past(PERIPH_CLK)))
    else $error("peripheral clock missed a toggle");
endmodule
`default_nettype wire

// file: rtl/crg_pin_sync.sv
// three-flop pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module crg_pin_sync #(
  parameter int unsigned W       = 10,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  arst_n,
  // pin carrier
  crg_sync_if.sync   pins
);
  // ==========================================
  // state
  typedef struct packed {
    logic [W-1:0] ff1;    // first stage, read only by ff2
    logic [W-1:0] ff2;    // second stage
    logic [W-1:0] ff3;    // third stage
    logic [W-1:0] clean;  // accepted level
  } crg_sync_s;

  crg_sync_s st_reg;  // registered state
  crg_sync_s st_next; // next state
  logic [W-1:0] agree; // second and third stages match

  // next state: shift and accept agreed bits
  always_comb begin
    st_next       = st_reg;
    agree         = ~(st_reg.ff2 ^ st_reg.ff3);
    st_next.ff1   = pins.raw;
    st_next.ff2   = st_reg.ff1;
    st_next.ff3   = st_reg.ff2;
    st_next.clean = (st_reg.ff3 & agree) | (st_reg.clean & ~agree);
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      st_reg <= st_next;
    end
  end

  // accepted levels
  assign pins.clean = st_reg.clean;
endmodule
`default_nettype wire
